// ### hdl/ssc_pkg.sv
// Shared constants, carriers and decode for the stepper sequencer and chopper
package ssc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Translator constants
  localparam logic [2:0] HOME_STATE = 3'h0;     // State 1, the home position
  localparam logic [3:0] HOME_PHASES = 4'h5;    // ABCD at home
  localparam int GHOST_W = 16;
  localparam int OSC_W = 16;
  localparam logic [GHOST_W-1:0] GHOST_IDLE = 16'h0000;
  localparam logic [GHOST_W-1:0] GHOST_LAST = 16'h0001;
  localparam logic [GHOST_W-1:0] GHOST_MIN = 16'h0001;
  localparam logic [OSC_W-1:0] OSC_CNT_RESET = 16'h0001;
  localparam logic [OSC_W-1:0] OSC_HALF_MIN = 16'h0001;
  localparam logic CHOP_RESET = 1'b0;           // Chopper off until first pulse
  localparam logic DIR_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic sync_in;         // Shared chopper clock line, input side
    logic current_sense_cd;
    logic current_sense_ab;
    logic chop_target;     // Low: gate inhibits, high: gate phases
    logic enable;
    logic trans_reset_n;
    logic half_step;
    logic rotation_sense;
    logic step_n;
  } ssc_pins_type;

  localparam int PIN_W = 9;
  localparam logic [PIN_W-1:0] PINS_IDLE = 9'h009;  // Step and reset idle high

  typedef struct packed {
    logic [3:0] phase;     // A, B, C, D from bit 3 down
    logic inhibit_ab_n;
    logic inhibit_cd_n;
  } ssc_drive_type;

  localparam ssc_drive_type DRIVE_RESET = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Phase pattern of each half-step state, index 0 is state 1
  function automatic logic [3:0] ssc_phase_of(input logic [2:0] idx);
    logic [3:0] p;
    p = HOME_PHASES;
    unique case (idx)
      3'h0: p = HOME_PHASES;
      3'h1: p = 4'h1;
      3'h2: p = 4'h9;
      3'h3: p = 4'h8;
      3'h4: p = 4'ha;
      3'h5: p = 4'h2;
      3'h6: p = 4'h6;
      3'h7: p = 4'h4;
    endcase
    return p;
  endfunction

endpackage

// ### hdl/ssc_chopper.sv
// One chopper flip-flop: set by oscillator pulse, cleared by over-current trip
`timescale 1ns/1ns
`default_nettype none
module ssc_chopper (
  // Clock, reset, freeze
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Chopper events
  input wire logic osc_pulse,
  input wire logic trip,
  // Drive permission
  output logic on_q
);
  import ssc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Set wins when pulse and trip coincide
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      on_q <= CHOP_RESET;
    end else if (ce) begin
      if (osc_pulse) begin
        on_q <= 1'b1;
      end else if (trip) begin
        on_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_chop_set_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    ce && osc_pulse |=> on_q)
    else $error("chopper not enabled by oscillator pulse");
  chk_chop_trip_off: assert property (@(posedge sys_clk) disable iff (rst)
    ce && trip && !osc_pulse |=> !on_q)
    else $error("chopper not disabled by trip");
  cov_chop_trip: cover property (@(posedge sys_clk) disable iff (rst)
    on_q ##1 !on_q);

endmodule
`default_nettype wire

// ### hdl/ssc_top.sv
// Stepper phase translator, step doubler, chopper oscillator and output logic
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Doubler mode adds one internal ghost step per external step pulse not followed by another within the ghost delay.
// - Ghost step follows its external step after a configured delay.
// - Doubler mode ignores chop target and sync line; chopper gates phases.
// - Doubler mode shows the inverted direction flip-flop state on its own output.
// - Outside doubler mode, with local oscillator enabled, its square wave is driven onto the sync line.
// - Outside doubler mode and without local oscillator, sync line input clocks the choppers.
// - Home indication active whenever translator sits in state 1 (0101).
// - Home pin is open collector: released when active, pulled low otherwise.
// - Active-low inhibit drives off the A/B driver stage.
// - Inhibit asserted on de-energized winding; chops current in inhibit mode.
// - Second active-low inhibit serves C/D, same behaviour as A/B.
// - Enable low forces both inhibits and all four phases low.
// - Chop target low gates inhibits; high gates the phase lines.
// - Translator advances one state in half step, two in full step, on each step pulse's rising edge.
// - Low pulse on translator reset returns it to state 1.
// - Without chopping each inhibit is the OR of its phase pair.
// - Chopper set by each oscillator pulse, cleared by its over-current trip.
module ssc_top (
  // Clock, reset, freeze
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Pins from host, bridge sense and sync line
  input wire ssc_pkg::ssc_pins_type pins,
  // Configuration
  input wire logic doubler_mode,
  input wire logic osc_local_en,
  input wire logic [ssc_pkg::GHOST_W-1:0] ghost_delay,
  input wire logic [ssc_pkg::OSC_W-1:0] osc_half,
  // Bridge drive
  output ssc_pkg::ssc_drive_type drive_q,
  // Open-collector home and direction memory
  output logic home_o_q,
  output logic home_oe_q,
  output logic dir_mem_q,
  // Sync line, output side
  output logic sync_o_q,
  output logic sync_oe_q
);
  import ssc_pkg::*;

  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] stab_q;
  ssc_pins_type pin_s;
  logic step_prev_q;
  logic sync_prev_q;
  logic step_rise;
  logic ext_pulse;
  logic trans_clr;
  logic dir_q;
  logic [2:0] state_q;
  logic [2:0] state_d;
  logic [GHOST_W-1:0] ghost_cnt_q;
  logic ghost_fire;
  logic [OSC_W-1:0] osc_cnt_q;
  logic osc_q;
  logic osc_wrap;
  logic local_pulse;
  logic use_ext;
  logic chop_pulse;
  logic [1:0] trip;
  logic [1:0] chop_on;
  logic gate_phase;
  logic [3:0] ph;
  logic ab_act;
  logic cd_act;
  ssc_drive_type drive_d;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronizers for every pin input
  generate
    for (genvar i = 0; i < PIN_W; i++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          meta_q[i] <= PINS_IDLE[i];
          stab_q[i] <= PINS_IDLE[i];
        end else if (ce) begin
          meta_q[i] <= pins[i];
          stab_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign pin_s = stab_q;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronized step and sync lines
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      step_prev_q <= PINS_IDLE[0];
      sync_prev_q <= PINS_IDLE[PIN_W-1];
    end else if (ce) begin
      step_prev_q <= pin_s.step_n;
      sync_prev_q <= pin_s.sync_in;
    end
  end
  assign step_rise = pin_s.step_n & ~step_prev_q;
  assign ext_pulse = pin_s.sync_in & ~sync_prev_q;
  assign trans_clr = ~pin_s.trans_reset_n;

  ////////////////////////////////////////////////////////////////////////////
  // Direction flip-flop, latched with each external step
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dir_q <= DIR_RESET;
    end else if (ce && step_rise) begin
      dir_q <= pin_s.rotation_sense;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ghost step delay; a new step restarts it, dropping a pending ghost unless that ghost fires in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ghost_cnt_q <= GHOST_IDLE;
    end else if (ce) begin
      if (step_rise && doubler_mode) begin
        ghost_cnt_q <= (ghost_delay < GHOST_MIN) ? GHOST_MIN : ghost_delay;
      end else if (ghost_cnt_q != GHOST_IDLE) begin
        ghost_cnt_q <= ghost_cnt_q - GHOST_LAST;
      end
    end
  end
  assign ghost_fire = (ghost_cnt_q == GHOST_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Next translator state: real and ghost steps, half or full stride
  always_comb begin
    logic [1:0] n;
    logic [2:0] delta;
    logic fwd;
    n = {1'b0, step_rise} + {1'b0, ghost_fire};
    delta = pin_s.half_step ? {1'b0, n} : {n, 1'b0};
    fwd = step_rise ? pin_s.rotation_sense : dir_q;
    state_d = fwd ? state_q + delta : state_q - delta;
  end

  // Translator state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= HOME_STATE;
    end else if (ce) begin
      if (trans_clr) begin
        state_q <= HOME_STATE;
      end else begin
        state_q <= state_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local chopper oscillator, square wave of osc_half cycles per half
  assign osc_wrap = (osc_cnt_q >= osc_half) || (osc_half < OSC_HALF_MIN);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_cnt_q <= OSC_CNT_RESET;
      osc_q <= 1'b0;
    end else if (ce) begin
      if (osc_wrap) begin
        osc_cnt_q <= OSC_CNT_RESET;
        osc_q <= ~osc_q;
      end else begin
        osc_cnt_q <= osc_cnt_q + OSC_CNT_RESET;
      end
    end
  end
  assign local_pulse = osc_wrap & ~osc_q;
  assign use_ext = ~osc_local_en & ~doubler_mode;
  assign chop_pulse = use_ext ? ext_pulse : local_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Chopper per phase pair
  assign trip = {pin_s.current_sense_cd, pin_s.current_sense_ab};
  generate
    for (genvar k = 0; k < 2; k++) begin : g_chop
      ssc_chopper u_chop (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .osc_pulse(chop_pulse),
        .trip(trip[k]),
        .on_q(chop_on[k])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output logic; a chopped pair in phase mode has both lines pulled high
  assign gate_phase = doubler_mode | pin_s.chop_target;
  assign ph = ssc_phase_of(state_q);
  assign ab_act = ph[3] | ph[2];
  assign cd_act = ph[1] | ph[0];
  always_comb begin
    drive_d = DRIVE_RESET;
    if (pin_s.enable) begin
      drive_d.phase[3:2] = (gate_phase && ab_act && !chop_on[0]) ? 2'h3 : ph[3:2];
      drive_d.phase[1:0] = (gate_phase && cd_act && !chop_on[1]) ? 2'h3 : ph[1:0];
      drive_d.inhibit_ab_n = ab_act & (gate_phase | chop_on[0]);
      drive_d.inhibit_cd_n = cd_act & (gate_phase | chop_on[1]);
    end
  end

  // Registered pin drivers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_q <= DRIVE_RESET;
      home_o_q <= 1'b0;
      home_oe_q <= 1'b0;
      dir_mem_q <= ~DIR_RESET;
      sync_o_q <= 1'b0;
      sync_oe_q <= 1'b0;
    end else if (ce) begin
      drive_q <= drive_d;
      home_o_q <= 1'b0;
      home_oe_q <= (state_q != HOME_STATE);
      dir_mem_q <= ~dir_q;
      sync_o_q <= osc_q;
      sync_oe_q <= osc_local_en & ~doubler_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_home_pin_state: assert property (
    ce |=> home_oe_q == (ssc_phase_of($past(state_q)) != HOME_PHASES))
    else $error("home indication does not follow state 1");
  chk_enable_forces_low: assert property (
    ce && !pin_s.enable |=> drive_q == DRIVE_RESET)
    else $error("outputs not low while disabled");
  chk_step_moves_state: assert property (
    ce && step_rise && !ghost_fire && !trans_clr |=> state_q != $past(state_q))
    else $error("step did not advance translator");
  chk_full_step_stride: assert property (
    ce && step_rise && !ghost_fire && !trans_clr && !pin_s.half_step |=> state_q[0] == $past(state_q[0]))
    else $error("full step did not skip a state");
  chk_ghost_delay_load: assert property (
    ce && step_rise && doubler_mode && ghost_delay > GHOST_MIN |=> ghost_cnt_q == $past(ghost_delay))
    else $error("ghost delay not loaded");
  chk_ghost_fires_once: assert property (
    ce && ghost_fire && !step_rise && !trans_clr && pin_s.half_step |=> state_q != $past(state_q) ##0
    ghost_cnt_q == GHOST_IDLE)
    else $error("ghost step missing");
  chk_reset_to_home: assert property (
    ce && trans_clr |=> state_q == HOME_STATE)
    else $error("translator reset failed");
  chk_inhibit_or_pair: assert property (
    ce && pin_s.enable && gate_phase |=> drive_q.inhibit_ab_n == ($past(ph[3]) | $past(ph[2])) &&
    drive_q.inhibit_cd_n == ($past(ph[1]) | $past(ph[0])))
    else $error("inhibit is not OR of phase pair");
  chk_inhibit_chop_gate: assert property (
    ce && pin_s.enable && !gate_phase && !chop_on[0] |=> !drive_q.inhibit_ab_n)
    else $error("inhibit not chopped");
  chk_dir_mem_follow: assert property (
    ce && step_rise ##1 ce |=> dir_mem_q == !$past(pin_s.rotation_sense, 2))
    else $error("direction memory wrong");
  chk_sync_drive_out: assert property (
    ce && osc_local_en && !doubler_mode |=> sync_oe_q && sync_o_q == $past(osc_q))
    else $error("sync line not driven");
  chk_ext_clock_used: assert property (
    ce && use_ext && ext_pulse |=> g_chop[0].u_chop.on_q)
    else $error("external sync did not clock chopper");

  cov_ghost_step: cover property (step_rise && doubler_mode ##[1:1000] ghost_fire);
  cov_home_return: cover property (state_q != HOME_STATE ##1 trans_clr ##1 state_q == HOME_STATE);
  cov_ext_sync: cover property (use_ext && ext_pulse);
  cov_wrap_back: cover property (state_q == 3'h7 ##1 state_q == HOME_STATE);

endmodule
`default_nettype wire

// ### test/ssc_host_model.sv
// Host step source and external chopper clock for the sequencer
`timescale 1ns/1ns
`default_nettype none
module ssc_host_model (
  // Clock and requests
  input wire logic sys_clk,
  input wire logic step_go,
  input wire logic sync_go,
  // Lines toward the device
  output logic step_n,
  output logic ext_sync
);
  logic [2:0] low_q = 3'h0;
  logic [2:0] clk_q = 3'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Active-low step pulse, four cycles, step on its rise
  always @(posedge sys_clk) begin
    if (step_go) begin
      low_q <= 3'h4;
    end else if (low_q != 3'h0) begin
      low_q <= low_q - 3'h1;
    end
  end
  assign step_n = (low_q == 3'h0);
  // One injected clock pulse, line still between pulses
  always @(posedge sys_clk) begin
    if (sync_go) begin
      clk_q <= 3'h4;
    end else if (clk_q != 3'h0) begin
      clk_q <= clk_q - 3'h1;
    end
  end
  assign ext_sync = (clk_q != 3'h0);
endmodule
`default_nettype wire

// ### test/tb_ssc_top.sv
// Self-checking bench for the stepper sequencer and chopper
`timescale 1ns/1ns
`default_nettype none
module tb_ssc_top;
  import ssc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic doubler_mode = 1'b0;
  logic osc_local_en = 1'b1;
  logic [GHOST_W-1:0] ghost_delay = 16'h0008;
  logic [OSC_W-1:0] osc_half = 16'h0004;
  logic sense_ab = 1'b0;
  logic sense_cd = 1'b0;
  logic chop_target = 1'b0;
  logic enable = 1'b1;
  logic ce_in = 1'b1;
  logic trans_reset_n = 1'b1;
  logic half_step = 1'b1;
  logic rotation_sense = 1'b1;
  logic step_go = 1'b0;
  logic sync_go = 1'b0;
  logic step_n, ext_sync, home_o_q, home_oe_q, dir_mem_q, sync_o_q, sync_oe_q;
  ssc_pins_type pins;
  ssc_drive_type drive_q;
  logic [3:0] seq [8] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4};
  logic [2:0] idx = 3'h0;
  logic dmem = 1'b1;
  logic chop_off = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  int seed = 75;
  string names[$];
  logic [9:0] exps[$];
  event look;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, pins and instances
  always #10 sys_clk = ~sys_clk;
  assign pins = {sync_oe_q ? sync_o_q : ext_sync, sense_cd, sense_ab, chop_target, enable,
    trans_reset_n, half_step, rotation_sense, step_n};
  ssc_host_model host (.sys_clk(sys_clk), .step_go(step_go), .sync_go(sync_go),
    .step_n(step_n), .ext_sync(ext_sync));
  ssc_top uut (.sys_clk(sys_clk), .rst(rst), .ce(ce_in), .pins(pins), .doubler_mode(doubler_mode),
    .osc_local_en(osc_local_en), .ghost_delay(ghost_delay), .osc_half(osc_half), .drive_q(drive_q),
    .home_o_q(home_o_q), .home_oe_q(home_oe_q), .dir_mem_q(dir_mem_q), .sync_o_q(sync_o_q),
    .sync_oe_q(sync_oe_q));
  ////////////////////////////////////////////////////////////////////////////
  // Expected output vector from the bench's own state
  function automatic logic [9:0] expv();
    logic [3:0] ph;
    logic iab, icd;
    ph = seq[idx];
    iab = ph[3] | ph[2];
    icd = ph[1] | ph[0];
    if (chop_off && chop_target) begin
      ph = 4'hf;
    end
    if (chop_off && !chop_target) begin
      iab = 1'b0;
      icd = 1'b0;
    end
    if (!enable) begin
      ph = 4'h0;
      iab = 1'b0;
      icd = 1'b0;
    end
    return {1'b0, osc_local_en & ~doubler_mode, idx != 3'h0, dmem, ph, iab, icd};
  endfunction
  // Queue a note for the watcher
  task automatic note(input string name);
    names.push_back(name);
    exps.push_back(expv());
    -> look;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Count sync line rises over sixteen cycles, sampled away from the launching edge
  task automatic check_sync(input int want);
    int rises;
    logic last;
    rises = 0;
    @(negedge sys_clk);
    last = sync_o_q;
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      if (sync_o_q === 1'b1 && last === 1'b0) begin
        rises++;
      end
      last = sync_o_q;
    end
    total_checks++;
    if (rises != want) begin
      err_count++;
      $display("[ERR] sync_o_q rises expected %0d seen %0d", want, rises);
    end
  endtask
  // One host step, plus the ghost step in doubler mode
  task automatic step(input logic d, input logic h);
    tick(1);
    rotation_sense <= d;
    half_step <= h;
    tick(3);
    step_go <= 1'b1;
    tick(1);
    step_go <= 1'b0;
    tick(12);
    idx = d ? idx + (h ? 3'h1 : 3'h2) : idx - (h ? 3'h1 : 3'h2);
    dmem = ~d;
    note("step");
    if (doubler_mode) begin
      tick(12);
      idx = d ? idx + (h ? 3'h1 : 3'h2) : idx - (h ? 3'h1 : 3'h2);
      note("ghost");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watcher: compare oldest note against the outputs
  initial begin
    forever begin
      @(look);
      @(negedge sys_clk);
      total_checks++;
      if (exps[0] !== {home_o_q, sync_oe_q, home_oe_q, dir_mem_q, drive_q}) begin
        err_count++;
        $display("[ERR] %s expected %h seen %h", names[0], exps[0],
          {home_o_q, sync_oe_q, home_oe_q, dir_mem_q, drive_q});
      end
      void'(names.pop_front());
      void'(exps.pop_front());
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    tick(20000);
    err_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tick(3);
    rst <= 1'b0;
    tick(14);
    note("reset");
    check_sync(2);
    for (int i = 0; i < 16; i++) begin
      step(1'($random(seed)), 1'($random(seed)));
    end
    enable <= 1'b0;
    tick(9);
    note("disable");
    enable <= 1'b1;
    trans_reset_n <= 1'b0;
    tick(5);
    trans_reset_n <= 1'b1;
    tick(8);
    idx = 3'h0;
    note("home");
    osc_local_en <= 1'b0;
    sense_ab <= 1'b1;
    sense_cd <= 1'b1;
    tick(10);
    chop_off = 1'b1;
    note("chop_inh");
    chop_target <= 1'b1;
    tick(10);
    note("chop_phase");
    sense_ab <= 1'b0;
    sense_cd <= 1'b0;
    tick(4);
    sync_go <= 1'b1;
    tick(1);
    sync_go <= 1'b0;
    tick(12);
    chop_off = 1'b0;
    note("ext_clock");
    // Step pulse while frozen must be lost, outputs held
    ce_in <= 1'b0;
    tick(1);
    step_go <= 1'b1;
    tick(1);
    step_go <= 1'b0;
    tick(8);
    note("freeze");
    ce_in <= 1'b1;
    doubler_mode <= 1'b1;
    chop_target <= 1'b0;
    tick(1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b0);
    tick(4);
    print_verdict();
  end
endmodule
`default_nettype wire
